// ---- design/cih_defines.svh ----
// constants for the interrupt, halt, lock and bus-cycle sequencer
`ifndef CIH_DEFINES_SVH
`define CIH_DEFINES_SVH

`define CIH_OFF_CTRL    12'h000
`define CIH_OFF_CMD     12'h004
`define CIH_OFF_ADDR    12'h008
`define CIH_OFF_WDATA   12'h00C
`define CIH_OFF_RDATA   12'h010
`define CIH_OFF_STATUS  12'h014
`define CIH_OFF_VECTOR  12'h018

`define CIH_CTRL_IE     0
`define CIH_CTRL_LOCK   1
`define CIH_CTRL_HALT   2
`define CIH_CTRL_WAIT   3
`define CIH_CTRL_END    4
`define CIH_CMD_GO      0
`define CIH_CMD_WRITE   1
`define CIH_CMD_MEM     2
`define CIH_CMD_HBE_N   3
`define CIH_CMD_LAST    4

`define CIH_NMI_TYPE    8'h02
`define CIH_ST_IRQ_ACK_STROBE     3'h0
`define CIH_ST_RD_IO    3'h1
`define CIH_ST_WR_IO    3'h2
`define CIH_ST_HALT     3'h3
`define CIH_ST_RD_MEM   3'h5
`define CIH_ST_WR_MEM   3'h6
`define CIH_ST_PASSIVE  3'h7

`endif

// ---- design/cih_pkg.sv ----
// types of the interrupt, halt, lock and bus-cycle sequencer
package cih_pkg;

	typedef enum logic [2:0] {S_IDLE, S_T1, S_T2, S_T3, S_TW, S_T4, S_HALT_ALE} cih_bst_t;
	typedef enum logic [2:0] {K_READ, K_WRITE, K_INTA1, K_INTA2, K_HALT} cih_kind_t;

	typedef struct packed {
		logic        ale;
		logic        rd_n;
		logic        wr_n;
		logic        irq_ack_strobe_n;
		logic        mem_io;
		logic        high_byte_enable_n;
		logic [15:0] muxed_addr_data_bus;
		logic        ad_oe;
		logic        xcvr_direction;
		logic        xcvr_output_enable_n;
		logic        lock_n;
		logic [2:0]  cycle_status;
		logic        ctl_oe;
		logic        hold_ack;
	} cih_lbus_t;

	typedef struct packed {
		cih_bst_t    bst;
		cih_kind_t   kind;
		logic        strap_done;
		logic        mode_max;
		logic        ie;
		logic        saved_ie;
		logic        locked;
		logic        irq_ack_strobe_lock;
		logic        irq_ack_strobe_seq;
		logic        halted;
		logic        waiting;
		logic        wait_refetch;
		logic        hold_ack;
		logic        rq_pend;
		logic        gt;
		logic        irq_smp;
		logic        cmd_write;
		logic        cmd_mem;
		logic        cmd_hbe_n;
		logic        cmd_last;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [7:0]  vec_type;
		logic [9:0]  vec_ptr;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		cih_lbus_t   pins;
	} cih_st_t;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic pend;
	} cih_nmi_st_t;

endpackage : cih_pkg

// ---- design/cih_nmi_latch.sv ----
// edge latch for the non-maskable interrupt pin
`timescale 1ns/1ps
`default_nettype none
module cih_nmi_latch (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic nrst_i,
	// pin and service
	input  wire logic nmi_i,
	input  wire logic clear_i,
	output logic      pend_o
);
	cih_pkg::cih_nmi_st_t s_reg;
	cih_pkg::cih_nmi_st_t s_next;

	always_comb
	begin
		s_next       = s_reg;
		// pin is asynchronous, so two stages before any edge logic
		s_next.sync1 = nmi_i;
		s_next.sync2 = s_reg.sync1;
		s_next.prev  = s_reg.sync2;
		if (clear_i)
			s_next.pend = 1'b0;
		// a fresh edge in the clearing cycle survives
		if (s_reg.sync2 && !s_reg.prev)
			s_next.pend = 1'b1;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign pend_o = s_reg.pend;
endmodule : cih_nmi_latch
`default_nettype wire

// ---- design/cih_core.sv ----
// interrupt, halt, lock and local bus-cycle sequencer with apb registers
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cih_defines.svh"
module cih_core (
	// clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              nrst_i,
	// apb slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [11:0]       paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic                   pready_o,
	output logic                   pslverr_o,
	output logic [31:0]            prdata_o,
	// external events
	input  wire logic              nmi_i,
	input  wire logic              maskable_irq_req_i,
	input  wire logic              test_n_i,
	input  wire logic              min_max_strap_i,
	input  wire logic              hold_i,
	input  wire logic              bus_request_grant_i,
	output logic                   bus_request_grant_o,
	// local bus
	input  wire logic              ready_i,
	input  wire logic [15:0]       ad_i,
	output cih_pkg::cih_lbus_t     lbus_o
);
	cih_pkg::cih_st_t r;
	cih_pkg::cih_st_t n;
	logic             nmi_pend;
	logic             svc_nmi;
	logic             svc_irq;
	logic             boundary;
	logic             apb_wr;
	logic             ctrl_wr;
	logic             cmd_wr;
	logic             lock_w;
	logic             free;

	function automatic logic [15:0] lane_mask(input logic hbe_n, input logic a0);
		case ({hbe_n, a0})
			2'b00:   lane_mask = 16'hFFFF;
			2'b01:   lane_mask = 16'hFF00;
			2'b10:   lane_mask = 16'h00FF;
			default: lane_mask = 16'h0000;
		endcase
	endfunction : lane_mask

	function automatic logic [9:0] vec_of(input logic [7:0] vtype);
		vec_of = {vtype, 2'b00};
	endfunction : vec_of

	function automatic logic [2:0] status_of(input cih_pkg::cih_st_t s);
		logic active;
		active = (s.bst == cih_pkg::S_T1) || (s.bst == cih_pkg::S_T2) ||
		         (s.bst == cih_pkg::S_T3) || (s.bst == cih_pkg::S_TW);
		status_of = `CIH_ST_PASSIVE;
		if (s.bst == cih_pkg::S_HALT_ALE)
			status_of = `CIH_ST_HALT;
		else if (active)
		begin
			case (s.kind)
				cih_pkg::K_INTA1: status_of = `CIH_ST_IRQ_ACK_STROBE;
				cih_pkg::K_INTA2: status_of = `CIH_ST_IRQ_ACK_STROBE;
				cih_pkg::K_READ:  status_of = s.cmd_mem ? `CIH_ST_RD_MEM : `CIH_ST_RD_IO;
				cih_pkg::K_WRITE: status_of = s.cmd_mem ? `CIH_ST_WR_MEM : `CIH_ST_WR_IO;
				default:          status_of = `CIH_ST_PASSIVE;
			endcase
		end
	endfunction : status_of

	function automatic cih_pkg::cih_lbus_t pins_of(input cih_pkg::cih_st_t s);
		logic mid;
		logic data;
		logic irq_ack_strobe;
		logic mn;
		mid  = (s.bst == cih_pkg::S_T2) || (s.bst == cih_pkg::S_T3) || (s.bst == cih_pkg::S_TW);
		data = mid || (s.bst == cih_pkg::S_T4);
		irq_ack_strobe = (s.kind == cih_pkg::K_INTA1) || (s.kind == cih_pkg::K_INTA2);
		mn   = !s.mode_max;
		pins_of                      = '0;
		// min mode halt gets one ALE and no strobes
		pins_of.ale                  = mn && ((s.bst == cih_pkg::S_T1) || (s.bst == cih_pkg::S_HALT_ALE));
		pins_of.rd_n                 = !(mn && mid && (s.kind == cih_pkg::K_READ));
		pins_of.wr_n                 = !(mn && mid && (s.kind == cih_pkg::K_WRITE));
		pins_of.irq_ack_strobe_n     = !(mn && mid && irq_ack_strobe);
		pins_of.mem_io               = s.cmd_mem && !irq_ack_strobe && ((s.bst == cih_pkg::S_T1) || data);
		pins_of.high_byte_enable_n   = s.cmd_hbe_n;
		// acknowledge cycles leave the address lines to the bus keepers
		pins_of.muxed_addr_data_bus  = (s.bst == cih_pkg::S_T1) ? s.addr :
		                               (s.wdata & lane_mask(s.cmd_hbe_n, s.addr[0]));
		pins_of.ad_oe                = !s.hold_ack && (((s.bst == cih_pkg::S_T1) && !irq_ack_strobe) ||
		                               (data && (s.kind == cih_pkg::K_WRITE)));
		pins_of.xcvr_direction       = (s.kind == cih_pkg::K_WRITE);
		pins_of.xcvr_output_enable_n = !(mn && data && (s.kind != cih_pkg::K_HALT));
		pins_of.lock_n               = !(s.locked || s.irq_ack_strobe_lock);
		pins_of.cycle_status         = s.mode_max ? status_of(s) : `CIH_ST_PASSIVE;
		pins_of.ctl_oe               = !s.hold_ack;
		pins_of.hold_ack             = s.hold_ack;
	endfunction : pins_of

	cih_nmi_latch u_nmi (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.nmi_i     (nmi_i),
		.clear_i   (svc_nmi),
		.pend_o    (nmi_pend)
	);

	always_comb
	begin
		n       = r;
		n.gt    = 1'b0;
		n.irq_smp = maskable_irq_req_i;
		// strap taken once, the first clock after reset release
		if (!r.strap_done)
		begin
			n.strap_done = 1'b1;
			n.mode_max   = !min_max_strap_i;
		end
		// apb: ready in the first cycle of the access phase, no wait states
		apb_wr    = psel_i && penable_i && r.pready && pwrite_i;
		ctrl_wr   = apb_wr && (paddr_i == `CIH_OFF_CTRL);
		cmd_wr    = apb_wr && (paddr_i == `CIH_OFF_CMD);
		lock_w    = ctrl_wr && pwdata_i[`CIH_CTRL_LOCK];
		n.pready  = psel_i && !penable_i;
		n.pslverr = 1'b0;
		if (psel_i && !penable_i)
		begin
			case (paddr_i)
				`CIH_OFF_CTRL:   n.prdata = {31'h00000000, r.ie};
				`CIH_OFF_CMD:    n.prdata = {27'h0000000, r.cmd_last, r.cmd_hbe_n, r.cmd_mem, r.cmd_write, 1'b0};
				`CIH_OFF_ADDR:   n.prdata = {16'h0000, r.addr};
				`CIH_OFF_WDATA:  n.prdata = {16'h0000, r.wdata};
				`CIH_OFF_RDATA:  n.prdata = {16'h0000, r.rdata};
				`CIH_OFF_STATUS: n.prdata = {20'h00000, !test_n_i, r.mode_max, r.irq_ack_strobe_seq, r.saved_ie,
				                             r.wait_refetch, r.rq_pend, r.hold_ack, nmi_pend, r.waiting,
				                             r.locked, r.halted, (r.bst != cih_pkg::S_IDLE)};
				`CIH_OFF_VECTOR: n.prdata = {14'h0000, r.vec_ptr, r.vec_type};
				default:
				begin
					n.prdata  = 32'h00000000;
					n.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_wr && (paddr_i == `CIH_OFF_ADDR))
			n.addr = pwdata_i[15:0];
		if (apb_wr && (paddr_i == `CIH_OFF_WDATA))
			n.wdata = pwdata_i[15:0];
		if (ctrl_wr)
			n.ie = pwdata_i[`CIH_CTRL_IE];
		if (lock_w)
			n.locked = 1'b1;
		if (ctrl_wr && pwdata_i[`CIH_CTRL_WAIT])
			n.wait_refetch = 1'b0;
		// instruction boundary: explicit end, or a halt / wait loop
		free     = (r.bst == cih_pkg::S_IDLE) && !r.hold_ack && !r.irq_ack_strobe_seq;
		boundary = free && ((ctrl_wr && pwdata_i[`CIH_CTRL_END]) || r.halted || r.waiting);
		svc_nmi  = boundary && nmi_pend;
		svc_irq  = boundary && !nmi_pend && r.irq_smp && r.ie;
		if (svc_nmi || svc_irq)
		begin
			n.saved_ie = r.ie;
			n.ie       = 1'b0;
			n.halted   = 1'b0;
			if (r.waiting)
				n.wait_refetch = 1'b1;
			n.waiting  = 1'b0;
		end
		if (svc_nmi)
		begin
			n.vec_type = `CIH_NMI_TYPE;
			n.vec_ptr  = vec_of(`CIH_NMI_TYPE);
		end
		if (r.waiting && !test_n_i)
			n.waiting = 1'b0;
		// hold: never inside the acknowledge pair, halt survives it
		if (free && hold_i && !svc_irq)
			n.hold_ack = 1'b1;
		if (r.hold_ack && !hold_i)
		begin
			n.hold_ack = 1'b0;
			if (r.halted)
				n.bst = cih_pkg::S_HALT_ALE;
		end
		// request/grant waits out any lock
		if (r.rq_pend && free && !r.locked && !r.irq_ack_strobe_lock && !svc_irq)
		begin
			n.gt      = 1'b1;
			n.rq_pend = 1'b0;
		end
		if (bus_request_grant_i)
			n.rq_pend = 1'b1;
		case (r.bst)
			cih_pkg::S_IDLE:
			begin
				if (svc_irq)
				begin
					n.kind     = cih_pkg::K_INTA1;
					n.irq_ack_strobe_seq = 1'b1;
					n.bst      = cih_pkg::S_T1;
				end
				else if (free && !hold_i && !r.halted && !r.waiting)
				begin
					if (cmd_wr && pwdata_i[`CIH_CMD_GO])
					begin
						n.cmd_write = pwdata_i[`CIH_CMD_WRITE];
						n.cmd_mem   = pwdata_i[`CIH_CMD_MEM];
						n.cmd_hbe_n = pwdata_i[`CIH_CMD_HBE_N];
						n.cmd_last  = pwdata_i[`CIH_CMD_LAST];
						n.kind      = pwdata_i[`CIH_CMD_WRITE] ? cih_pkg::K_WRITE : cih_pkg::K_READ;
						n.bst       = cih_pkg::S_T1;
					end
					else if (ctrl_wr && pwdata_i[`CIH_CTRL_HALT])
					begin
						n.kind = cih_pkg::K_HALT;
						n.bst  = cih_pkg::S_HALT_ALE;
					end
					else if (ctrl_wr && pwdata_i[`CIH_CTRL_WAIT] && test_n_i)
						n.waiting = 1'b1;
				end
			end
			cih_pkg::S_HALT_ALE:
			begin
				n.halted = 1'b1;
				n.bst    = cih_pkg::S_IDLE;
			end
			cih_pkg::S_T1:
			begin
				n.bst = cih_pkg::S_T2;
				if (r.mode_max)
					n.irq_ack_strobe_lock = (r.kind == cih_pkg::K_INTA1);
			end
			cih_pkg::S_T2:
				n.bst = cih_pkg::S_T3;
			cih_pkg::S_T3, cih_pkg::S_TW:
			begin
				n.bst = ready_i ? cih_pkg::S_T4 : cih_pkg::S_TW;
				if (ready_i && (r.kind == cih_pkg::K_INTA2))
				begin
					n.vec_type = ad_i[7:0];
					n.vec_ptr  = vec_of(ad_i[7:0]);
				end
				if (ready_i && (r.kind == cih_pkg::K_READ))
					n.rdata = ad_i & lane_mask(r.cmd_hbe_n, r.addr[0]);
			end
			cih_pkg::S_T4:
			begin
				n.bst = cih_pkg::S_IDLE;
				if (r.kind == cih_pkg::K_INTA1)
				begin
					n.kind = cih_pkg::K_INTA2;
					n.bst  = cih_pkg::S_T1;
				end
				if (r.kind == cih_pkg::K_INTA2)
					n.irq_ack_strobe_seq = 1'b0;
				if (r.cmd_last && !lock_w && ((r.kind == cih_pkg::K_READ) || (r.kind == cih_pkg::K_WRITE)))
					n.locked = 1'b0;
			end
			default:
				n.bst = cih_pkg::S_IDLE;
		endcase
		n.pins = pins_of(n);
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			r                            <= '0;
			r.bst                        <= cih_pkg::S_IDLE;
			r.cmd_hbe_n                  <= 1'b1;
			r.pins.rd_n                  <= 1'b1;
			r.pins.wr_n                  <= 1'b1;
			r.pins.irq_ack_strobe_n      <= 1'b1;
			r.pins.high_byte_enable_n    <= 1'b1;
			r.pins.xcvr_output_enable_n  <= 1'b1;
			r.pins.lock_n                <= 1'b1;
			r.pins.cycle_status          <= `CIH_ST_PASSIVE;
			r.pins.ctl_oe                <= 1'b1;
		end
		else
			r <= n;
	end

	assign pready_o            = r.pready;
	assign pslverr_o           = r.pslverr;
	assign prdata_o            = r.prdata;
	assign bus_request_grant_o = r.gt;
	assign lbus_o              = r.pins;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_nmi_vector_two: assert property (svc_nmi |=> (r.vec_ptr == 10'h008) && !r.ie)
		else $error("nmi not dispatched as type two");
	a_nmi_over_irq: assert property ((boundary && nmi_pend && r.irq_smp && r.ie)
		|=> (r.bst != cih_pkg::S_T1) && (r.vec_type == `CIH_NMI_TYPE))
		else $error("maskable served while nmi pending");
	a_irq_enable_gate: assert property (svc_irq |-> r.ie && r.irq_smp ##1 !r.ie && r.saved_ie)
		else $error("maskable served while masked");
	a_ack_back_to_back: assert property ((r.bst == cih_pkg::S_T4 && r.kind == cih_pkg::K_INTA1)
		|=> (r.bst == cih_pkg::S_T1) && (r.kind == cih_pkg::K_INTA2))
		else $error("second acknowledge did not follow");
	a_max_lock_span: assert property ((r.mode_max && r.bst == cih_pkg::S_T1 && r.kind == cih_pkg::K_INTA1)
		|=> !lbus_o.lock_n [*3])
		else $error("acknowledge lock not held");
	a_ack_lock_end: assert property ((r.mode_max && !r.locked && !lock_w && r.bst == cih_pkg::S_T1 &&
		r.kind == cih_pkg::K_INTA2) |-> !lbus_o.lock_n ##1 lbus_o.lock_n)
		else $error("acknowledge lock not released at second T2");
	a_no_hold_in_ack: assert property ($rose(r.hold_ack) |-> !$past(r.irq_ack_strobe_seq))
		else $error("hold granted inside acknowledge pair");
	a_vector_times_four: assert property ((r.kind == cih_pkg::K_INTA2 && ready_i &&
		(r.bst == cih_pkg::S_T3 || r.bst == cih_pkg::S_TW)) |=> r.vec_ptr == {$past(ad_i[7:0]), 2'b00})
		else $error("vector pointer wrong");
	a_halt_indication: assert property ((r.bst == cih_pkg::S_HALT_ALE) |-> (r.mode_max ?
		(lbus_o.cycle_status == 3'h3) : (lbus_o.ale && lbus_o.rd_n && lbus_o.wr_n)) ##1 r.halted)
		else $error("halt indication wrong");
	a_lock_prefix_low: assert property (lock_w |=> !lbus_o.lock_n)
		else $error("lock not asserted after prefix");
	a_grant_after_lock: assert property (r.gt |-> !$past(r.locked) && !$past(r.irq_ack_strobe_lock))
		else $error("grant issued under lock");
	a_wait_no_cycles: assert property (r.waiting |-> r.bst == cih_pkg::S_IDLE)
		else $error("bus cycle during wait loop");
	a_read_phases: assert property ((r.bst == cih_pkg::S_T1 && r.kind == cih_pkg::K_READ && !r.mode_max)
		|-> lbus_o.ale && lbus_o.ad_oe ##1 !lbus_o.rd_n && !lbus_o.ad_oe && !lbus_o.ale)
		else $error("read phase signals wrong");
	a_write_strobe: assert property ((r.kind == cih_pkg::K_WRITE && !r.mode_max && r.bst == cih_pkg::S_T2)
		|-> !lbus_o.wr_n && lbus_o.ad_oe)
		else $error("write strobe or data missing");
	a_four_clocks: assert property ((r.bst == cih_pkg::S_T1) |=> (r.bst == cih_pkg::S_T2) ##1
		(r.bst == cih_pkg::S_T3) ##1 (r.bst == cih_pkg::S_T4 || r.bst == cih_pkg::S_TW))
		else $error("bus cycle shorter than four clocks");
	a_wait_state: assert property ((r.bst == cih_pkg::S_T3 && !ready_i) |=> r.bst == cih_pkg::S_TW)
		else $error("no wait state on not ready");
endmodule : cih_core
`default_nettype wire

// ---- tb/cih_bus_model.sv ----
// behavioural memory and interrupt controller on the multiplexed local bus
`timescale 1ns/1ps
`default_nettype none
module cih_bus_model (
	// clock, reset, setup
	input  wire logic               clk_i,
	input  wire logic               nrst_i,
	input  wire logic               min_mode_i,
	input  wire logic [1:0]         waits_i,
	input  wire logic [7:0]         type_i,
	// local bus
	input  wire cih_pkg::cih_lbus_t lbus_i,
	output logic                    ready_o,
	output logic [15:0]             ad_o
);
	logic [15:0] mem [0:15];
	logic [15:0] adr;
	logic [15:0] last;
	logic [3:0]  cnt;
	logic        hbe_n;
	logic        rd;
	logic        ack;
	logic        act;
	logic        ack_q;
	logic        second;

	assign rd = min_mode_i ? !lbus_i.rd_n : (lbus_i.cycle_status inside {3'h1, 3'h5});
	assign ack = min_mode_i ? !lbus_i.irq_ack_strobe_n : (lbus_i.cycle_status == 3'h0);
	assign act = min_mode_i ? (rd || ack || !lbus_i.wr_n) : !(lbus_i.cycle_status inside {3'h3, 3'h7});
	// slow device: ready stays low for the chosen number of wait states in min mode, one fewer in max mode (count starts at T2 in min mode, at T1 in max mode)
	assign ready_o = act && (cnt > {2'h0, waits_i});
	// a released bus shows the inverse of its last value, never a stale copy
	assign ad_o = rd ? mem[adr[4:1]] : (ack && second) ? {~last[15:8], type_i} : ~last;
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cnt    <= 4'h0;
			last   <= 16'h0;
			ack_q  <= 1'b0;
			second <= 1'b0;
			adr    <= 16'h0;
			hbe_n  <= 1'b1;
		end
		else
		begin
			cnt   <= act ? cnt + 4'h1 : 4'h0;
			last  <= ad_o;
			ack_q <= ack;
			if (ack_q && !ack)
				second <= !second;
			if (lbus_i.ale)
			begin
				adr   <= lbus_i.muxed_addr_data_bus;
				hbe_n <= lbus_i.high_byte_enable_n;
			end
			if (!lbus_i.wr_n && ready_o)
			begin
				if (!hbe_n)
					mem[adr[4:1]][15:8] <= lbus_i.muxed_addr_data_bus[15:8];
				if (!adr[0])
					mem[adr[4:1]][7:0] <= lbus_i.muxed_addr_data_bus[7:0];
			end
		end
	end
endmodule : cih_bus_model
`default_nettype wire

// ---- tb/cih_core_bench.sv ----
// self-checking bench of the sequencer over apb and the local bus
`timescale 1ns/1ps
`default_nettype none
`include "cih_defines.svh"
module cih_core_bench;
	logic               clk = 1'b0;
	logic               nrst = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [11:0]        paddr = 12'h0;
	logic [31:0]        pwdata = 32'h0;
	logic               pready_o;
	logic               pslverr_o;
	logic [31:0]        prdata_o;
	logic               nmi = 1'b0;
	logic               irq = 1'b0;
	logic               test_n = 1'b1;
	logic               strap = 1'b1;
	logic               hold = 1'b0;
	logic               rq = 1'b0;
	logic               gnt;
	logic               ready;
	logic [15:0]        ad;
	logic [1:0]         waits = 2'h0;
	logic               slv;
	logic               ale_q = 1'b0;
	logic               ack_q = 1'b1;
	cih_pkg::cih_lbus_t lbus;
	int                 err_total = 0;
	int                 checked = 0;
	int                 n_ale = 0, n_ack = 0, n_wr = 0, n_str = 0, n_lock = 0, n_gnt = 0, n_sack = 0;
	int                 s, s2;

	always #4 clk = ~clk;

	cih_core dut (.ref_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
		.nmi_i(nmi), .maskable_irq_req_i(irq), .test_n_i(test_n), .min_max_strap_i(strap), .hold_i(hold),
		.bus_request_grant_i(rq), .bus_request_grant_o(gnt), .ready_i(ready), .ad_i(ad), .lbus_o(lbus));

	cih_bus_model model (.clk_i(clk), .nrst_i(nrst), .min_mode_i(strap), .waits_i(waits), .type_i(8'h45),
		.lbus_i(lbus), .ready_o(ready), .ad_o(ad));

	// edge counters for ALE and the acknowledge strobe, cycle counters for the rest, compared as differences
	always @(posedge clk)
	begin
		ale_q <= lbus.ale;
		ack_q <= lbus.irq_ack_strobe_n;
		n_ale += int'(lbus.ale && !ale_q);
		n_ack += int'(!lbus.irq_ack_strobe_n && ack_q);
		n_wr += int'(!lbus.wr_n);
		n_str += int'(!lbus.wr_n || !lbus.rd_n);
		n_lock += int'(!lbus.lock_n);
		n_gnt += int'(gnt);
		n_sack += int'(lbus.cycle_status == 3'h0);
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready_o !== 1'b1 && ++n < 20);
		if (pready_o !== 1'b1)
			err_total++;
		r = prdata_o;
		slv = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r & m, e);
	endtask : rd

	task automatic settle;
		logic [31:0] r;
		int n;
		n = 0;
		do apb(1'b0, `CIH_OFF_STATUS, 32'h0, r); while (r[0] !== 1'b0 && ++n < 30);
		if (r[0] !== 1'b0)
			err_total++;
	endtask : settle

	task automatic cyc(input logic [15:0] a, input logic [15:0] d, input logic [4:0] c);
		wr(`CIH_OFF_ADDR, {16'h0, a});
		wr(`CIH_OFF_WDATA, {16'h0, d});
		wr(`CIH_OFF_CMD, {27'h0, c});
		settle;
	endtask : cyc

	task automatic pulse_nmi;
		nmi <= 1'b1;
		repeat (3) @(posedge clk);
		nmi <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse_nmi

	task automatic end_sim;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd(`CIH_OFF_STATUS, 32'hFFFF_FFFF, 32'h0);
		chk({28'h0, lbus.lock_n, lbus.cycle_status}, 32'hF);
		rd(12'h01C, 32'hFFFF_FFFF, 32'h0);
		chk({31'h0, slv}, 32'h1);
		// byte lanes, first write stretched by two wait states
		s = n_wr;
		s2 = n_ale;
		waits <= 2'h2;
		cyc(16'h0004, 16'h1234, 5'h07);
		chk(32'(n_wr - s), 32'h4);
		waits <= 2'h0;
		cyc(16'h0004, 16'hABCD, 5'h0F);
		cyc(16'h0005, 16'hEF99, 5'h07);
		cyc(16'h0004, 16'h0, 5'h05);
		rd(`CIH_OFF_RDATA, 32'hFFFF, 32'hEFCD);
		cyc(16'h0005, 16'h0, 5'h05);
		rd(`CIH_OFF_RDATA, 32'hFFFF, 32'hEF00);
		cyc(16'h0004, 16'h0, 5'h0D);
		rd(`CIH_OFF_RDATA, 32'hFFFF, 32'h00CD);
		cyc(16'h0005, 16'h0, 5'h0D);
		rd(`CIH_OFF_RDATA, 32'hFFFF, 32'h0);
		chk(32'(n_ale - s2), 32'h7);
		// nmi beats a pending maskable request and needs no bus cycles
		wr(`CIH_OFF_CTRL, 32'h1);
		irq <= 1'b1;
		pulse_nmi;
		rd(`CIH_OFF_STATUS, 32'h10, 32'h10);
		s = n_ack;
		wr(`CIH_OFF_CTRL, 32'h11);
		rd(`CIH_OFF_VECTOR, 32'hFFFF_FFFF, 32'h802);
		rd(`CIH_OFF_STATUS, 32'h110, 32'h100);
		rd(`CIH_OFF_CTRL, 32'h1, 32'h0);
		wr(`CIH_OFF_CTRL, 32'h10);
		chk(32'(n_ack - s), 32'h0);
		// acknowledge pair; request dropped and hold raised after first strobe
		wr(`CIH_OFF_CTRL, 32'h1);
		wr(`CIH_OFF_CTRL, 32'h11);
		for (int i = 0; i < 40 && n_ack == s; i++) @(posedge clk);
		irq <= 1'b0;
		hold <= 1'b1;
		for (int i = 0; i < 40 && n_ack < s + 2; i++) @(posedge clk);
		chk({31'h0, lbus.hold_ack}, 32'h0);
		repeat (8) @(posedge clk);
		chk({31'h0, lbus.hold_ack}, 32'h1);
		hold <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(n_ack - s), 32'h2);
		rd(`CIH_OFF_VECTOR, 32'hFFFF_FFFF, 32'h11445);
		// halt: lone latch pulse, kept through a hold, left on nmi
		s = n_ale;
		s2 = n_str;
		wr(`CIH_OFF_CTRL, 32'h4);
		repeat (3) @(posedge clk);
		chk(32'(n_ale - s), 32'h1);
		chk(32'(n_str - s2), 32'h0);
		hold <= 1'b1;
		repeat (4) @(posedge clk);
		chk({30'h0, lbus.hold_ack, lbus.ctl_oe}, 32'h2);
		hold <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(n_ale - s), 32'h2);
		rd(`CIH_OFF_STATUS, 32'h2, 32'h2);
		pulse_nmi;
		repeat (4) @(posedge clk);
		rd(`CIH_OFF_STATUS, 32'h2, 32'h0);
		// lock prefix defers a request/grant until its last cycle ends
		s = n_gnt;
		wr(`CIH_OFF_CTRL, 32'h2);
		@(posedge clk);
		chk({31'h0, lbus.lock_n}, 32'h0);
		rq <= 1'b1;
		@(posedge clk);
		rq <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(n_gnt - s), 32'h0);
		cyc(16'h0006, 16'h5555, 5'h17);
		repeat (3) @(posedge clk);
		chk({31'h0, lbus.lock_n}, 32'h1);
		chk(32'(n_gnt - s), 32'h1);
		// wait-for-test idles the bus until the test pin goes low
		s = n_ale;
		wr(`CIH_OFF_CTRL, 32'h8);
		repeat (8) @(posedge clk);
		rd(`CIH_OFF_STATUS, 32'h8, 32'h8);
		chk(32'(n_ale - s), 32'h0);
		test_n <= 1'b0;
		repeat (4) @(posedge clk);
		rd(`CIH_OFF_STATUS, 32'h8, 32'h0);
		test_n <= 1'b1;
		// maximum mode: status codes and lock across the acknowledge pair
		nrst <= 1'b0;
		strap <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd(`CIH_OFF_STATUS, 32'h400, 32'h400);
		s = n_lock;
		s2 = n_sack;
		irq <= 1'b1;
		wr(`CIH_OFF_CTRL, 32'h1);
		wr(`CIH_OFF_CTRL, 32'h11);
		settle;
		irq <= 1'b0;
		chk(32'(n_lock - s), 32'h4);
		chk({31'h0, n_sack != s2}, 32'h1);
		wr(`CIH_OFF_CTRL, 32'h4);
		@(posedge clk);
		chk({29'h0, lbus.cycle_status}, 32'h3);
		rd(`CIH_OFF_STATUS, 32'h2, 32'h2);
		end_sim;
	end

	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#80000;
		err_total++;
		end_sim;
	end
endmodule : cih_core_bench
`default_nettype wire
